// >>> hw/ksr_pkg.sv
// constants, states and carriers of the key scan and reset control block
package ksr_pkg;

	// ****************************************
	// register map (byte addresses)
	// ****************************************
	localparam logic [7:0] KSR_CTRL_OFS    = 8'h00;
	localparam logic [7:0] KSR_DISP_LO_OFS = 8'h04;
	localparam logic [7:0] KSR_DISP_HI_OFS = 8'h08;
	localparam logic [7:0] KSR_KEY_OFS     = 8'h0C;
	localparam logic [7:0] KSR_STAT_OFS    = 8'h10;

	// control register fields
	localparam int KSR_SLEEP_SEL_A_BIT = 0;
	localparam int KSR_SLEEP_SEL_B_BIT = 1;
	localparam int KSR_SCAN_SEL_A_BIT  = 2;
	localparam int KSR_SCAN_SEL_B_BIT  = 3;
	localparam int KSR_CTRL_W          = 4;
	localparam logic [3:0] KSR_CTRL_RST = 4'h0;

	// key register fields
	localparam int KSR_KEY_W         = 20;
	localparam int KSR_SLEEP_ACK_BIT = 20;

	// status register fields
	localparam int KSR_STAT_RESET_BIT = 0;
	localparam int KSR_STAT_REQ_BIT   = 1;
	localparam int KSR_STAT_SLEEP_BIT = 2;

	// display latch
	localparam int KSR_DISP_W    = 48;
	localparam int KSR_DISP_HI_W = 16;

	// ****************************************
	// timing, in oscillator periods
	// ****************************************
	localparam int KSR_SCAN_T = 192;
	localparam int KSR_REQ_T  = 420;
	localparam int KSR_LINE_T = KSR_SCAN_T / 4;
	localparam int KSR_CNT_W  = 10;

	// ****************************************
	// scan line patterns and reset values
	// ****************************************
	localparam logic [3:0] KSR_LINES_ALL   = 4'hF;
	localparam logic [3:0] KSR_LINES_RST   = 4'h8;
	localparam logic [3:0] KSR_LINES_SL_01 = 4'h8;
	localparam logic [3:0] KSR_LINES_SL_10 = 4'hC;
	localparam logic [2:0] KSR_LOADED_ALL  = 3'h7;

	typedef enum logic [1:0] {
		KSR_IDLE = 2'b00,
		KSR_SCAN = 2'b01,
		KSR_HOLD = 2'b11,
		KSR_REQ  = 2'b10
	} ksr_state_e;

	// bus address phase held for the data phase
	typedef struct packed {
		logic       wr;
		logic [7:0] ofs;
	} ksr_ap_s;

endpackage : ksr_pkg

// >>> hw/ksr_key_scan_reset.sv
// key matrix scan engine and system reset control with an AHB-Lite register slave
//
// Our own choices: the register offsets and the AHB-Lite slave port.
`timescale 1ns/10ps
`default_nettype none

// Behaviour
// - normal idle: all four scan lines high
// - press starts scanning until all released
// - simultaneous presses set every matching bit
// - press beyond 420 periods pulls request low
// - chip enable high releases request line
// - key read clears request, starts new scan
// - sleep: scan lines follow sleep select bits
// - sleep press restarts oscillator and scanning
// - sleep key read rescans, stays in sleep
// - select a=0, b=1: only fourth line high
// - reset blanks display, stops scan, clears keys
// - supply detect enters system reset
// - reset ends at chip enable fall after loads
// - oscillator stopped during reset, sleep decides after
// - drivers off in reset, latch still loads
// - reset returns scan sequencer to idle
// - control and display registers and bus untouched by system reset
// - reset forces shared pins segment, outputs low
// - reset drives fourth scan line high
// - request stays released throughout reset
// - two agreeing 192-period scans confirm press
// - any sleep bit sleeps; both zero wakes
// - segment-mode scan pins zero their key bits
// - sleep ack bit shows mode at press
module ksr_key_scan_reset
	import ksr_pkg::*;
#(
	parameter int OSC_DIV = 1
) (
	// clock and reset
	input  wire logic        i_mclk,
	input  wire logic        i_rst,
	// AHB-Lite slave
	input  wire logic        i_hsel,
	input  wire logic [31:0] i_haddr,
	input  wire logic [1:0]  i_htrans,
	input  wire logic        i_hwrite,
	input  wire logic [2:0]  i_hsize,
	input  wire logic [31:0] i_hwdata,
	input  wire logic        i_hready,
	output logic      [31:0] o_hrdata,
	output logic             o_hreadyout,
	output logic             o_hresp,
	// pins from outside the clock domain
	input  wire logic [4:0]  i_key_return_inputs,
	input  wire logic        i_chip_enable,
	input  wire logic        i_supply_detect_reset,
	// key matrix and request line
	output logic      [3:0]  o_scan_drive_lines,
	output logic             o_req_data_o,
	output logic             o_req_data_oe,
	// display side
	output logic             o_display_on,
	output logic             o_force_segment,
	output logic      [47:0] o_display_bits,
	output logic             o_osc_run
);

	// ****************************************
	// functions
	// ****************************************
	// position inside the current scan; the counter spans two scans
	function automatic logic [KSR_CNT_W-1:0] scan_pos(input logic [KSR_CNT_W-1:0] c);
		scan_pos = (c >= KSR_CNT_W'(KSR_SCAN_T)) ? c - KSR_CNT_W'(KSR_SCAN_T) : c;
	endfunction : scan_pos

	function automatic logic [1:0] line_of(input logic [KSR_CNT_W-1:0] c);
		line_of = 2'(scan_pos(c) / KSR_CNT_W'(KSR_LINE_T));
	endfunction : line_of

	// ****************************************
	// input synchronisers
	// ****************************************
	logic [6:0] sync1_reg;
	logic [6:0] sync2_reg;
	logic [6:0] sync3_reg;
	logic [6:0] filt_reg;
	logic [6:0] filt_next;
	logic       ce_prev_reg;

	// a change counts only once the second and third stages agree
	assign filt_next = (sync2_reg & sync3_reg) | (filt_reg & (sync2_reg | sync3_reg));

	always_ff @(posedge i_mclk) begin
		sync1_reg   <= {i_supply_detect_reset, i_chip_enable, i_key_return_inputs};
		sync2_reg   <= sync1_reg;
		sync3_reg   <= sync2_reg;
		filt_reg    <= i_rst ? 7'h00 : filt_next;
		ce_prev_reg <= i_rst ? 1'b0 : filt_reg[5];
	end

	logic [4:0] keys_in;
	logic       ce_hi;
	logic       supply_detect_reset;
	logic       ce_fall;
	assign keys_in = filt_reg[4:0];
	assign ce_hi   = filt_reg[5];
	assign supply_detect_reset    = filt_reg[6];
	assign ce_fall = ce_prev_reg & ~ce_hi;

	// ****************************************
	// bus slave
	// ****************************************
	ksr_ap_s    ap_reg;
	logic       ap_valid_reg;
	logic       ap_take;
	logic       ap_rd;
	logic [7:0] ap_ofs;
	logic       wr_ctrl;
	logic       wr_lo;
	logic       wr_hi;
	logic       rd_key;
	logic [31:0] rd_mux;

	logic [3:0]  ctrl_reg;
	logic [31:0] disp_lo_reg;
	logic [15:0] disp_hi_reg;
	logic [19:0] key_data_reg;
	logic        sleep_ack_reg;
	logic        sys_reset_reg;
	ksr_state_e  state_reg;

	assign ap_take = i_hsel & i_htrans[1] & i_hready;
	assign ap_rd   = ap_take & ~i_hwrite;
	assign ap_ofs  = i_haddr[7:0];
	// only whole aligned words are served; other widths land on the same word
	assign wr_ctrl = ap_valid_reg & ap_reg.wr & (ap_reg.ofs == KSR_CTRL_OFS);
	assign wr_lo   = ap_valid_reg & ap_reg.wr & (ap_reg.ofs == KSR_DISP_LO_OFS);
	assign wr_hi   = ap_valid_reg & ap_reg.wr & (ap_reg.ofs == KSR_DISP_HI_OFS);
	assign rd_key  = ap_rd & (ap_ofs == KSR_KEY_OFS) & (i_haddr[31:8] == 24'h000000);

	logic [31:0] key_word;
	logic [31:0] stat_word;
	logic        sleep;
	assign key_word  = {11'h000, sleep_ack_reg, key_data_reg};
	assign stat_word = {29'h00000000, sleep, state_reg == KSR_REQ, sys_reset_reg};

	assign rd_mux = (i_haddr[31:8] != 24'h000000) ? 32'h00000000 :
		(ap_ofs == KSR_CTRL_OFS)    ? {28'h0000000, ctrl_reg} :
		(ap_ofs == KSR_DISP_LO_OFS) ? disp_lo_reg :
		(ap_ofs == KSR_DISP_HI_OFS) ? {16'h0000, disp_hi_reg} :
		(ap_ofs == KSR_KEY_OFS)     ? key_word :
		(ap_ofs == KSR_STAT_OFS)    ? stat_word : 32'h00000000;

	// bus side is never touched by the system reset, only by i_rst
	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			ap_valid_reg <= 1'b0;
			ap_reg       <= '0;
			o_hrdata     <= 32'h00000000;
			o_hreadyout  <= 1'b1;
			o_hresp      <= 1'b0;
		end else begin
			ap_valid_reg <= ap_take;
			ap_reg       <= '{wr: i_hwrite, ofs: (i_haddr[31:8] == 24'h000000) ? ap_ofs : 8'hFF};
			o_hrdata     <= ap_rd ? rd_mux : o_hrdata;
			o_hreadyout  <= 1'b1;
			o_hresp      <= 1'b0;
		end
	end

	// control and display latch load even while the system is in reset
	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			ctrl_reg    <= KSR_CTRL_RST;
			disp_lo_reg <= 32'h00000000;
			disp_hi_reg <= 16'h0000;
		end else begin
			if (wr_ctrl) ctrl_reg <= i_hwdata[KSR_CTRL_W-1:0];
			if (wr_lo) disp_lo_reg <= i_hwdata;
			if (wr_hi) disp_hi_reg <= i_hwdata[KSR_DISP_HI_W-1:0];
		end
	end

	logic scan_sel_a;
	logic scan_sel_b;
	assign sleep      = ctrl_reg[KSR_SLEEP_SEL_A_BIT] | ctrl_reg[KSR_SLEEP_SEL_B_BIT];
	assign scan_sel_a = ctrl_reg[KSR_SCAN_SEL_A_BIT];
	assign scan_sel_b = ctrl_reg[KSR_SCAN_SEL_B_BIT];

	// ****************************************
	// system reset
	// ****************************************
	logic [2:0] loaded_reg;
	logic [2:0] loaded_next;
	logic       sys_reset_next;

	assign loaded_next = supply_detect_reset ? 3'h0 : (loaded_reg | {wr_hi, wr_lo, wr_ctrl});
	assign sys_reset_next = supply_detect_reset ? 1'b1 :
		(sys_reset_reg & (loaded_reg == KSR_LOADED_ALL) & ce_fall) ? 1'b0 :
		sys_reset_reg;

	// the block powers up inside system reset
	always_ff @(posedge i_mclk) begin
		sys_reset_reg <= i_rst ? 1'b1 : sys_reset_next;
		loaded_reg    <= i_rst ? 3'h0 : loaded_next;
	end

	// ****************************************
	// oscillator period tick
	// ****************************************
	logic [15:0] div_reg;
	logic        osc_run;
	logic        tick;

	// stopped in reset and in idle sleep; a key press wakes it
	assign osc_run = ~sys_reset_reg & (~sleep | (state_reg != KSR_IDLE));
	assign tick    = osc_run & (div_reg == 16'(OSC_DIV - 1));

	always_ff @(posedge i_mclk) begin
		if (i_rst | ~osc_run | tick) div_reg <= 16'h0000;
		else div_reg <= div_reg + 16'h0001;
	end

	// ****************************************
	// scan sequencer
	// ****************************************
	logic [KSR_CNT_W-1:0] cnt_reg;
	logic [KSR_CNT_W-1:0] cnt_next;
	logic [19:0]          cur_reg;
	logic [19:0]          prev_reg;
	logic [19:0]          key_mask;
	ksr_state_e           state_next;
	logic [1:0]           line_idx;
	logic                 slot_end;
	logic                 end_first;
	logic                 end_second;
	logic                 hold_done;
	logic                 key_read;
	logic [3:0]           idle_lines;
	logic [3:0]           lines_next;

	assign line_idx   = line_of(cnt_reg);
	assign slot_end   = tick & (state_reg == KSR_SCAN) &
		(scan_pos(cnt_reg) % KSR_CNT_W'(KSR_LINE_T) == KSR_CNT_W'(KSR_LINE_T - 1));
	assign end_first  = tick & (state_reg == KSR_SCAN) & (cnt_reg == KSR_CNT_W'(KSR_SCAN_T));
	assign end_second = tick & (state_reg == KSR_SCAN) & (cnt_reg == KSR_CNT_W'(2 * KSR_SCAN_T));
	assign hold_done  = tick & (state_reg == KSR_HOLD) & (cnt_reg == KSR_CNT_W'(KSR_REQ_T - 1));
	// a read while the system is in reset has no effect
	assign key_read   = rd_key & ~sys_reset_reg & (state_reg == KSR_REQ);

	// shared pins used as segments report no keys on their lines
	assign key_mask = {10'h3FF, {5{~scan_sel_a}}, {5{~(scan_sel_a | scan_sel_b)}}};

	always_comb begin
		state_next = state_reg;
		cnt_next   = tick ? cnt_reg + KSR_CNT_W'(1) : cnt_reg;
		unique case (state_reg)
			KSR_IDLE: begin
				cnt_next = '0;
				if (keys_in != 5'h00) state_next = KSR_SCAN;
			end
			KSR_SCAN: begin
				if ((end_first | end_second) & (cur_reg == 20'h00000)) begin
					state_next = KSR_IDLE;
				end else if (end_second & (cur_reg == prev_reg)) begin
					state_next = KSR_HOLD;
				end else if (end_second) begin
					cnt_next = '0;
				end
			end
			KSR_HOLD: begin
				if (hold_done) state_next = KSR_REQ;
			end
			KSR_REQ: begin
				cnt_next = '0;
				if (key_read) state_next = KSR_SCAN;
			end
		endcase
	end

	always_ff @(posedge i_mclk) begin
		if (i_rst | sys_reset_reg) begin
			state_reg     <= KSR_IDLE;
			cnt_reg       <= '0;
			cur_reg       <= 20'h00000;
			prev_reg      <= 20'h00000;
			key_data_reg  <= 20'h00000;
			sleep_ack_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			cnt_reg   <= cnt_next;
			if (slot_end) cur_reg[line_idx * 5 +: 5] <= keys_in;
			if (end_first) prev_reg <= cur_reg;
			if (hold_done) key_data_reg <= cur_reg & key_mask;
			if ((state_reg == KSR_IDLE) & (state_next == KSR_SCAN)) sleep_ack_reg <= sleep;
		end
	end

	// ****************************************
	// pin drive
	// ****************************************
	assign idle_lines =
		~sleep ? KSR_LINES_ALL :
		(ctrl_reg[1:0] == 2'b10) ? KSR_LINES_SL_01 :
		(ctrl_reg[1:0] == 2'b01) ? KSR_LINES_SL_10 : KSR_LINES_ALL;

	// follows the forced-segment flag edge for edge, so line four is high whenever it is set
	assign lines_next = sys_reset_next ? KSR_LINES_RST :
		(((state_reg == KSR_SCAN) ? (4'h1 << line_idx) : idle_lines) &
		{2'b11, ~scan_sel_a, ~(scan_sel_a | scan_sel_b)});

	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			o_scan_drive_lines <= KSR_LINES_RST;
			o_req_data_o       <= 1'b0;
			o_req_data_oe      <= 1'b0;
			o_display_on       <= 1'b0;
			o_force_segment    <= 1'b1;
			o_osc_run          <= 1'b0;
		end else begin
			o_scan_drive_lines <= lines_next;
			o_req_data_o       <= 1'b0;
			// open drain: pulled low only while a request waits
			o_req_data_oe      <= (state_next == KSR_REQ) & ~ce_hi & ~sys_reset_next;
			o_display_on       <= ~sys_reset_next & ~sleep;
			o_force_segment    <= sys_reset_next;
			// next-state form keeps the run flag in step with the display enable
			o_osc_run          <= ~sys_reset_next & (~sleep | (state_next != KSR_IDLE));
		end
	end

	assign o_display_bits = {disp_hi_reg, disp_lo_reg};

endmodule : ksr_key_scan_reset

`default_nettype wire

// >>> tb/ksr_key_pad.sv
// key matrix model: a return row sees any pressed key on a line driven high
`timescale 1ns/10ps
`default_nettype none
module ksr_key_pad (
	input  wire logic [3:0]  i_lines,
	input  wire logic [19:0] i_pressed,
	output logic      [4:0]  o_returns
);
	// ideal diodes, so a key on a low line adds nothing and rows rest pulled low
	always_comb begin
		o_returns = 5'h0;
		for (int k = 0; k < 20; k++) begin
			o_returns[k % 5] = o_returns[k % 5] | (i_lines[k / 5] & i_pressed[k]);
		end
	end
endmodule : ksr_key_pad
`default_nettype wire

// >>> tb/ksr_key_scan_reset_asserts.sv
// port checker of the key scan and reset block
`timescale 1ns/10ps
`default_nettype none
module ksr_asserts
	import ksr_pkg::*;
#(
	parameter int OSC_DIV = 1
) (
	input wire logic       i_mclk,
	input wire logic       i_rst,
	input wire logic       i_chip_enable,
	input wire logic       i_supply_detect_reset,
	input wire logic       o_hreadyout,
	input wire logic       o_hresp,
	input wire logic [3:0] o_scan_drive_lines,
	input wire logic       o_req_data_o,
	input wire logic       o_req_data_oe,
	input wire logic       o_display_on,
	input wire logic       o_force_segment,
	input wire logic       o_osc_run
);
	default clocking @(posedge i_mclk); endclocking
	default disable iff (i_rst);
	logic [3:0]  lines_reg;
	logic [15:0] dwell_reg;
	// cycles the scan lines have held their present value
	always_ff @(posedge i_mclk) begin
		lines_reg <= i_rst ? KSR_LINES_RST : o_scan_drive_lines;
		dwell_reg <= (i_rst || o_scan_drive_lines != lines_reg) ? 16'h0 : dwell_reg + 16'h1;
	end
	property p_reset_line4;
		o_force_segment |-> o_scan_drive_lines[3];
	endproperty
	a_reset_line4: assert property (p_reset_line4) else $error("line four low in reset");
	property p_reset_quiet;
		o_force_segment && $past(o_force_segment) |-> !o_req_data_oe && !o_display_on && !o_osc_run;
	endproperty
	a_reset_quiet: assert property (p_reset_quiet) else $error("activity in reset");
	property p_req_ce;
		i_chip_enable [*6] |-> !o_req_data_oe;
	endproperty
	a_req_ce: assert property (p_req_ce) else $error("request held under chip enable");
	property p_req_wire;
		o_req_data_oe |-> !o_req_data_o;
	endproperty
	a_req_wire: assert property (p_req_wire) else $error("request line not pulled low");
	property p_scan_dwell;
		$onehot(lines_reg) && o_scan_drive_lines == (lines_reg << 1)
			|-> dwell_reg == 16'(KSR_LINE_T * OSC_DIV - 1);
	endproperty
	a_scan_dwell: assert property (p_scan_dwell) else $error("scan line dwell wrong");
	property p_disp_osc;
		o_display_on |-> o_osc_run;
	endproperty
	a_disp_osc: assert property (p_disp_osc) else $error("display on, oscillator off");
	property p_enter_reset;
		i_supply_detect_reset [*6] |-> o_force_segment;
	endproperty
	a_enter_reset: assert property (p_enter_reset) else $error("supply detect ignored");
	property p_bus_ok;
		o_hreadyout && !o_hresp;
	endproperty
	a_bus_ok: assert property (p_bus_ok) else $error("bus stalled or erred");
	c_req: cover property ($rose(o_req_data_oe));
	c_release: cover property ($fell(o_force_segment));
	c_step: cover property ($onehot(lines_reg) && o_scan_drive_lines == (lines_reg << 1));
endmodule : ksr_asserts
`default_nettype wire

// >>> tb/tb_top.sv
// self-checking bench of the key scan and reset block
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin errors++; \
	$display("[FAIL] %s exp %h got %h", n, e, g); end end
module tb_top import ksr_pkg::*; ;
	logic i_mclk = 0, i_rst = 1, hsel = 0, hwrite = 0, ce = 0, sdet = 0;
	logic [31:0] haddr = 0, hwdata = 0, lo, hi, e, g;
	logic [1:0]  htrans = 0;
	logic [19:0] pressed = 0, m;
	wire logic [31:0] hrdata;
	wire logic        hrdy, hresp, oe, odo, don, fseg, osc;
	wire logic [4:0]  ret;
	wire logic [3:0]  lines;
	wire logic [47:0] disp;
	// open-drain request line with its pull-up
	wire logic        req_line = oe ? 1'b0 : 1'b1;
	int errors = 0, total_checks = 0, cyc = 0, n, k;
	logic [31:0] eq[$], gq[$];
	string nq[$], nm;
	event ev;
	ksr_key_scan_reset #(.OSC_DIV(1)) dut (.i_mclk(i_mclk), .i_rst(i_rst), .i_hsel(hsel),
		.i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2),
		.i_hwdata(hwdata), .i_hready(hrdy), .o_hrdata(hrdata), .o_hreadyout(hrdy),
		.o_hresp(hresp), .i_key_return_inputs(ret), .i_chip_enable(ce),
		.i_supply_detect_reset(sdet), .o_scan_drive_lines(lines), .o_req_data_o(odo),
		.o_req_data_oe(oe), .o_display_on(don), .o_force_segment(fseg),
		.o_display_bits(disp), .o_osc_run(osc));
	ksr_key_pad u_pad (.i_lines(lines), .i_pressed(pressed), .o_returns(ret));
	initial forever #25 i_mclk = ~i_mclk;
	// a hang costs a mismatch and closes the run
	always @(posedge i_mclk) begin
		cyc++;
		if (cyc == 40000) begin
			errors++;
			close_out();
		end
	end
	initial forever begin
		@(ev);
		while (eq.size() > 0) begin
			nm = nq.pop_front();
			e = eq.pop_front();
			g = gq.pop_front();
			`CHK(nm, e, g)
		end
	end
	task automatic note(input string s, input logic [31:0] x, input logic [31:0] y);
		nq.push_back(s);
		eq.push_back(x);
		gq.push_back(y);
		->ev;
	endtask : note
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= 2'b10;
		hwrite <= w;
		@(posedge i_mclk);
		while (hrdy !== 1'b1) @(posedge i_mclk);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		@(posedge i_mclk);
		while (hrdy !== 1'b1) @(posedge i_mclk);
		r = hrdata;
	endtask : bus
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] x;
		bus(1'b1, a, d, x);
	endtask : wr
	task automatic rdc(input string s, input logic [7:0] a, input logic [31:0] x);
		logic [31:0] y;
		bus(1'b0, a, 32'h0, y);
		note(s, x, y);
	endtask : rdc
	task automatic cycles(input int c);
		repeat (c) @(posedge i_mclk);
	endtask : cycles
	// press, time the request, read the key word, expect the line released
	task automatic press(input logic [19:0] mk, input logic [31:0] x);
		pressed <= mk;
		n = 0;
		while (oe !== 1'b1 && n < 2000) begin
			@(posedge i_mclk);
			n++;
		end
		note("latency", 32'h1, {31'h0, n >= 420 && n <= 440});
		rdc("key", KSR_KEY_OFS, x);
		cycles(1);
		note("req cleared", 32'h1, {31'h0, req_line});
	endtask : press
	task automatic load_all();
		wr(KSR_CTRL_OFS, 32'h0);
		wr(KSR_DISP_LO_OFS, lo);
		wr(KSR_DISP_HI_OFS, hi);
		ce <= 1'b1;
		cycles(4);
		ce <= 1'b0;
		cycles(8);
		note("released", 32'h0, {31'h0, fseg});
	endtask : load_all
	task automatic close_out();
		// notes raised in this time step may not have been compared yet
		while (eq.size() > 0) begin
			nm = nq.pop_front();
			e = eq.pop_front();
			g = gq.pop_front();
			`CHK(nm, e, g)
		end
		$display("checks %0d mismatches %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : close_out
	initial begin
		void'($urandom(42563));
		cycles(3);
		i_rst <= 1'b0;
		cycles(1);
		// ****************************************
		// power-up reset and release
		// ****************************************
		note("reset lines", {28'h0, KSR_LINES_RST}, {28'h0, lines});
		note("forced segment", 32'h1, {31'h0, fseg});
		rdc("stat", KSR_STAT_OFS, 32'h1);
		lo = $urandom;
		hi = {16'h0, 16'($urandom)};
		load_all();
		note("disp lo", lo, disp[31:0]);
		note("disp hi", hi, {16'h0, disp[47:32]});
		note("idle lines", {28'h0, KSR_LINES_ALL}, {28'h0, lines});
		$display("test reset done");
		// ****************************************
		// normal mode keys
		// ****************************************
		k = $urandom_range(19, 0);
		// two keys at most, so the controller never has to drop the word
		m = (20'h1 << k) | (20'h1 << ((k + 1 + $urandom_range(18, 0)) % 20));
		press(m, {12'h0, m});
		pressed <= m;
		cycles(480);
		note("rescan", 32'h1, {31'h0, oe});
		ce <= 1'b1;
		cycles(6);
		note("ce release", 32'h1, {31'h0, req_line});
		ce <= 1'b0;
		cycles(6);
		rdc("key again", KSR_KEY_OFS, {12'h0, m});
		pressed <= 20'h0;
		cycles(900);
		note("back idle", {28'h0, KSR_LINES_ALL}, {28'h0, lines});
		wr(KSR_CTRL_OFS, 32'h4);
		m = (20'h1 << $urandom_range(9, 0)) | (20'h1 << (10 + $urandom_range(9, 0)));
		press(m, {12'h0, m & 20'hFFC00});
		pressed <= 20'h0;
		cycles(900);
		$display("test normal done");
		// ****************************************
		// sleep mode
		// ****************************************
		wr(KSR_CTRL_OFS, 32'h2);
		cycles(2);
		note("sleep lines", {28'h0, KSR_LINES_SL_01}, {28'h0, lines});
		note("osc stop", 32'h0, {31'h0, osc});
		pressed <= 20'h1;
		cycles(600);
		note("low line no wake", 32'h0, {31'h0, oe});
		m = 20'h1 << (15 + $urandom_range(4, 0));
		press(m, {11'h0, 1'b1, m});
		rdc("stays asleep", KSR_STAT_OFS, 32'h4);
		pressed <= 20'h0;
		cycles(900);
		wr(KSR_CTRL_OFS, 32'h1);
		cycles(2);
		note("sleep 10", {28'h0, KSR_LINES_SL_10}, {28'h0, lines});
		wr(KSR_CTRL_OFS, 32'h3);
		cycles(2);
		note("sleep 11", {28'h0, KSR_LINES_ALL}, {28'h0, lines});
		wr(KSR_CTRL_OFS, 32'h0);
		cycles(2);
		note("wake osc", 32'h1, {31'h0, osc});
		$display("test sleep done");
		// ****************************************
		// supply drop and odd addresses
		// ****************************************
		sdet <= 1'b1;
		cycles(8);
		note("supply reset", 32'h1, {31'h0, fseg});
		sdet <= 1'b0;
		wr(KSR_KEY_OFS, 32'hFFFFFFFF);
		rdc("key cleared", KSR_KEY_OFS, 32'h0);
		rdc("unmapped", 8'h14, 32'h0);
		load_all();
		$display("test supply done");
		close_out();
	end
endmodule : tb_top
bind ksr_key_scan_reset ksr_asserts #(.OSC_DIV(OSC_DIV)) u_chk (.i_mclk(i_mclk),
	.i_rst(i_rst), .i_chip_enable(i_chip_enable),
	.i_supply_detect_reset(i_supply_detect_reset), .o_hreadyout(o_hreadyout),
	.o_hresp(o_hresp), .o_scan_drive_lines(o_scan_drive_lines),
	.o_req_data_o(o_req_data_o), .o_req_data_oe(o_req_data_oe),
	.o_display_on(o_display_on), .o_force_segment(o_force_segment), .o_osc_run(o_osc_run));
`default_nettype wire
